// ===== pllmc_ctrl.sv
// Purpose: register file and digital control of the divider and modulation loop
// Assumes: ref_tick and loop_tick are single-cycle pulses synchronous to clk_sys
// Notes: loss-of-lock is seen through the synchroniser, so the fail flag sets
//        two or three cycles after the analogue lock drops
`timescale 1ns/10ps
`default_nettype none
module pllmc_ctrl
	import pllmc_pkg::*;
#(
	parameter int LOCK_SETTLE_CYCLES = LOCK_SETTLE_CYC
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic reg_supervisor,
	output logic [31:0] reg_rdata,
	// analogue loop side
	input wire logic ref_tick,
	input wire logic loop_tick,
	input wire logic pll_lock_async,
	input wire logic pll_powered,
	input wire logic pll_select,
	// divider settings to the loop
	output logic [3:0] in_div_code,
	output logic [4:0] in_div_ratio,
	output logic ref_inhibit,
	output logic [4:0] out_div_ratio,
	output logic [6:0] loop_div_code,
	output logic loop_div_valid,
	// system clock divider
	output logic [1:0] sys_div_code,
	output logic switch_busy,
	// modulation settings to the loop
	output logic mod_strobe,
	output logic mod_active,
	output logic mod_spread_type,
	output logic [12:0] mod_period,
	output logic [14:0] mod_inc_step,
	// status
	output logic pll_fail,
	output logic clock_ready
);
	// software-visible state
	logic [3:0] input_divider_code;
	logic [1:0] output_divider_code;
	logic [6:0] loop_divider_code;
	logic progressive_switch_enable;
	logic lock_event;
	logic fail_mask;
	logic fail_flag;
	logic strobe_bypass;
	logic spread_type;
	logic [12:0] period_reg;
	logic modulation_enable;
	logic [14:0] step_reg;
	// internal state
	logic locked_s;
	logic locked_d;
	logic mod_en_d;
	logic [1:0] strobe_ticks;
	logic [$clog2(LOCK_SETTLE_CYCLES + 1) - 1:0] settle_cnt;
	logic [1:0] sw_div;
	logic sw_busy;

	// address decode and write qualification
	wire hit_ctl = (reg_addr == OFS_CONTROL);
	wire hit_mod = (reg_addr == OFS_MODULATION);
	wire wr_ok = reg_write && reg_supervisor;
	wire wr_ctl = wr_ok && hit_ctl;
	wire wr_mod = wr_ok && hit_mod;

	// lock edges, taken from the synchronised level only
	wire lock_change = locked_s ^ locked_d;
	wire lock_rise = locked_s && !locked_d;
	wire lock_loss = locked_d && !locked_s && pll_powered;
	wire mod_en_rise = modulation_enable && !mod_en_d;

	// flag updates: a hardware set wins over a software clear
	wire clr_event = wr_ctl && reg_wdata[CTL_LOCK_EVENT];
	wire clr_fail = wr_ctl && reg_wdata[CTL_FAIL_FLAG];
	wire next_lock_event = lock_change || (lock_event && !clr_event);
	wire next_fail_flag = lock_loss || (fail_flag && !clr_fail);

	// strobe control
	wire strobe_start = (mod_en_rise && locked_s) || (lock_rise && modulation_enable);
	wire strobe_done = mod_strobe && ref_tick && (strobe_ticks == STROBE_REF_CYCLES - 2'h1);
	wire apply_mod = strobe_bypass || strobe_done;

	// lock status bit
	// read-back images
	wire [31:0] ctl_image = {11'h000, fail_flag, fail_mask, locked_s, lock_event,
		progressive_switch_enable, 1'b0, loop_divider_code, 2'h0, output_divider_code,
		input_divider_code};
	wire [31:0] mod_image = {1'b0, step_reg, modulation_enable, period_reg, spread_type,
		strobe_bypass};
	wire [31:0] read_mux = hit_ctl ? ctl_image : (hit_mod ? mod_image : 32'h0000_0000);

	// lock indication crossing
	pllmc_sync u_lock_sync (
		.clk_sys(clk_sys),
		.reset(reset),
		.async_in(pll_lock_async),
		.sync_out(locked_s)
	);

	// progressive switching sequencer
	pllmc_switch u_switch (
		.clk_sys(clk_sys),
		.reset(reset),
		.enable(progressive_switch_enable),
		.locked(locked_s),
		.select(pll_select),
		.loop_tick(loop_tick),
		.div_code(sw_div),
		.busy(sw_busy)
	);

	// control register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			input_divider_code <= RST_IDF;
			output_divider_code <= RST_ODF;
			loop_divider_code <= RST_LOOP_DIVIDER_CODE;
			progressive_switch_enable <= 1'b0;
			fail_mask <= 1'b0;
		end else if (wr_ctl) begin
			input_divider_code <= reg_wdata[CTL_IDF_LSB +: 4];
			output_divider_code <= reg_wdata[CTL_ODF_LSB +: 2];
			loop_divider_code <= reg_wdata[CTL_LOOP_DIVIDER_CODE_LSB +: 7];
			progressive_switch_enable <= reg_wdata[CTL_SWITCH_EN];
			fail_mask <= reg_wdata[CTL_FAIL_MASK];
		end
	end

	// modulation register
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			strobe_bypass <= 1'b0;
			spread_type <= 1'b0;
			period_reg <= 13'h0000;
			modulation_enable <= 1'b0;
			step_reg <= 15'h0000;
		end else if (wr_mod) begin
			strobe_bypass <= reg_wdata[MOD_BYPASS];
			spread_type <= reg_wdata[MOD_SPREAD];
			period_reg <= reg_wdata[MOD_PERIOD_LSB +: 13];
			modulation_enable <= reg_wdata[MOD_ENABLE];
			step_reg <= reg_wdata[MOD_STEP_LSB +: 15];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			lock_event <= 1'b0;
			fail_flag <= 1'b0;
			locked_d <= 1'b0;
			mod_en_d <= 1'b0;
		end else begin
			lock_event <= next_lock_event;
			fail_flag <= next_fail_flag;
			locked_d <= locked_s;
			mod_en_d <= modulation_enable;
		end
	end

	// strobe held for two reference cycles
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mod_strobe <= 1'b0;
			strobe_ticks <= 2'h0;
		end else if (strobe_start && !mod_strobe) begin
			mod_strobe <= 1'b1;
			strobe_ticks <= 2'h0;
		end else if (strobe_done) begin
			mod_strobe <= 1'b0;
			strobe_ticks <= 2'h0;
		end else if (mod_strobe && ref_tick) begin
			strobe_ticks <= strobe_ticks + 2'h1;
		end
	end

	// applied modulation settings move only on strobe or bypass
	// spread type and period passed as binary fields
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mod_spread_type <= 1'b0;
			mod_period <= 13'h0000;
			mod_inc_step <= 15'h0000;
		end else if (apply_mod) begin
			mod_spread_type <= spread_type;
			mod_period <= period_reg;
			mod_inc_step <= step_reg;
		end
	end

	// divider ratios decoded for the loop
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			in_div_code <= RST_IDF;
			in_div_ratio <= 5'h01;
			ref_inhibit <= 1'b0;
			out_div_ratio <= 5'h02;
			loop_div_code <= RST_LOOP_DIVIDER_CODE;
			loop_div_valid <= 1'b1;
		end else begin
			in_div_code <= input_divider_code;
			in_div_ratio <= pllmc_in_ratio(input_divider_code);
			ref_inhibit <= (input_divider_code == IDF_INHIBIT);
			out_div_ratio <= pllmc_out_ratio(output_divider_code);
			loop_div_code <= loop_divider_code;
			loop_div_valid <= pllmc_loop_ok(loop_divider_code);
		end
	end

	// status outputs; settle counter helps software hold off
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mod_active <= 1'b0;
			pll_fail <= 1'b0;
			sys_div_code <= 2'h0;
			switch_busy <= 1'b0;
			settle_cnt <= '0;
			clock_ready <= 1'b0;
		end else begin
			mod_active <= modulation_enable;
			pll_fail <= fail_flag && !fail_mask;
			sys_div_code <= sw_div;
			switch_busy <= sw_busy;
			if (!locked_s) begin
				settle_cnt <= '0;
			end else if (settle_cnt != LOCK_SETTLE_CYCLES[$bits(settle_cnt) - 1:0]) begin
				settle_cnt <= settle_cnt + 1'b1;
			end
			clock_ready <= locked_s && (settle_cnt == LOCK_SETTLE_CYCLES[$bits(settle_cnt) - 1:0]);
		end
	end

	// read data, valid only in the cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_read ? read_mux : 32'h0000_0000;
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_input_ratio_plus1: assert property (
		##1 in_div_ratio == $past(input_divider_code) + 5'h01)
		else $error("input ratio is not code plus one");
	chk_output_ratio_map: assert property (output_divider_code == 2'h3 |=>
		out_div_ratio == 5'h10)
		else $error("output code 11 did not give divide by 16");
	chk_lock_event_set: assert property (lock_change |=> lock_event)
		else $error("lock transition did not set the event flag");
	chk_status_readback: assert property (reg_read && hit_ctl |=>
		reg_rdata[CTL_LOCK_STATUS] == $past(locked_s))
		else $error("lock status read back wrong");
	chk_fail_output_mask: assert property (
		##1 pll_fail == ($past(fail_flag) && !$past(fail_mask)))
		else $error("fail output does not follow flag and mask");
	chk_fail_flag_set: assert property (lock_loss |=> fail_flag)
		else $error("loss of lock did not set the fail flag");
	chk_mod_hold_nostrobe: assert property (!strobe_bypass && !strobe_done |=>
		$stable(mod_period) && $stable(mod_inc_step))
		else $error("modulation settings changed without strobe");
	chk_spread_applied: assert property (strobe_done |=>
		mod_spread_type == $past(spread_type))
		else $error("spread type not applied on strobe");
	chk_mod_enable_follow: assert property (##1 mod_active == $past(modulation_enable))
		else $error("modulation activity does not follow enable");
	chk_user_write_block: assert property (reg_write && !reg_supervisor |=>
		$stable(input_divider_code) && $stable(modulation_enable))
		else $error("user-mode write changed a register");
	chk_strobe_two_ticks: assert property ($fell(mod_strobe) |->
		$past(ref_tick) && $past(strobe_ticks) == 2'h1)
		else $error("strobe ended before two reference cycles");

	// inhibit code must stop the reference path
	chk_inhibit_on_code: assert property (input_divider_code == IDF_INHIBIT |=>
		ref_inhibit)
		else $error("inhibit code did not raise the inhibit output");
	// codes outside the table carry no ratio
	chk_loop_code_range: assert property (
		loop_divider_code < LOOP_DIVIDER_CODE_MIN || loop_divider_code > LOOP_DIVIDER_CODE_MAX |=> !loop_div_valid)
		else $error("undefined loop code flagged as valid");
	// no event flag without a lock transition
	chk_event_no_spurious: assert property (!lock_change && !lock_event |=>
		!lock_event)
		else $error("event flag set without a lock transition");
	// no fail flag without a powered loss of lock
	chk_fail_needs_loss: assert property (!lock_loss && !fail_flag |=> !fail_flag)
		else $error("fail flag set without a loss of lock");
	// a write of one clears the fail flag when no new loss arrives
	chk_fail_clear_write: assert property (fail_flag && !lock_loss && clr_fail |=>
		!fail_flag)
		else $error("fail flag did not clear on write of one");
	// strobe only rises from an enable or lock start condition
	chk_strobe_from_start: assert property ($rose(mod_strobe) |->
		$past(strobe_start))
		else $error("strobe rose without a start condition");
	// bypass passes the register settings straight through
	chk_bypass_tracks_regs: assert property (strobe_bypass |=>
		mod_period == $past(period_reg) && mod_inc_step == $past(step_reg))
		else $error("bypass did not pass the settings through");
	// period and step land together on the strobe
	chk_period_on_strobe: assert property (strobe_done |=>
		mod_period == $past(period_reg) && mod_inc_step == $past(step_reg))
		else $error("period or step not applied on strobe");
endmodule // pllmc_ctrl
`default_nettype wire

// ===== pllmc_pkg.sv
// Purpose: constants, register map and helper functions of the loop divider and modulation control
// Assumes: 32-bit register port, one clock at 250 MHz
// Notes: shared by the control top, its switching sequencer and the bench
// Operation
// - input divider is code plus one; code 1111 inhibits the reference clock
// - output divider codes 00..11 give divide by 2, 4, 8, 16
// - loop divider code 32..96 is the feedback ratio; others undefined
// - progressive switching starts at divide by 8 and steps down to 1
// - lock-event flag sets on every lock or unlock transition
// - lock status reads 1 while locked, 0 while unlocked
// - fail mask 1 suppresses the failure output, 0 passes it
// - loss of lock while powered sets fail flag; cleared by writing 1
// - without bypass, modulation settings reach the loop only on strobe
// - spread type 0 is centre spread, 1 is down spread
// - modulation period is a binary count of reference over four modulation
// - modulation only while enable is 1, otherwise unmodulated
// - control and modulation writes only from supervisor accesses
// - strobe stays high two reference cycles; from enable rise or lock rise
package pllmc_pkg;
	// register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_MODULATION = 8'h04;
	// control register fields
	localparam int CTL_IDF_LSB = 0;
	localparam int CTL_ODF_LSB = 4;
	localparam int CTL_LOOP_DIVIDER_CODE_LSB = 8;
	localparam int CTL_SWITCH_EN = 16;
	localparam int CTL_LOCK_EVENT = 17;
	localparam int CTL_LOCK_STATUS = 18;
	localparam int CTL_FAIL_MASK = 19;
	localparam int CTL_FAIL_FLAG = 20;
	// modulation register fields
	localparam int MOD_BYPASS = 0;
	localparam int MOD_SPREAD = 1;
	localparam int MOD_PERIOD_LSB = 2;
	localparam int MOD_ENABLE = 15;
	localparam int MOD_STEP_LSB = 16;
	// reset values, inhibit code and loop divider code range
	localparam logic [3:0] RST_IDF = 4'h0;
	localparam logic [1:0] RST_ODF = 2'h0;
	localparam logic [6:0] RST_LOOP_DIVIDER_CODE = 7'h20;
	localparam logic [3:0] IDF_INHIBIT = 4'hF;
	localparam logic [6:0] LOOP_DIVIDER_CODE_MIN = 7'h20;
	localparam logic [6:0] LOOP_DIVIDER_CODE_MAX = 7'h60;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int LOCK_SETTLE_US = 200;
	localparam int LOCK_SETTLE_CYC = LOCK_SETTLE_US * CLK_MHZ;
	localparam logic [1:0] STROBE_REF_CYCLES = 2'h2;
	// progressive switching dwell, in loop output cycles
	localparam logic [5:0] DWELL_DIV8 = 6'h08;
	localparam logic [5:0] DWELL_DIV4 = 6'h10;
	localparam logic [5:0] DWELL_DIV2 = 6'h20;
	// system divider selection: 0 = /1, 1 = /2, 2 = /4, 3 = /8
	typedef enum {PS_IDLE, PS_DIV8, PS_DIV4, PS_DIV2, PS_DONE} pllmc_sw_state_t;

	function automatic logic [4:0] pllmc_in_ratio(input logic [3:0] code);
		pllmc_in_ratio = {1'b0, code} + 5'h01;
	endfunction

	function automatic logic [4:0] pllmc_out_ratio(input logic [1:0] code);
		pllmc_out_ratio = 5'h02 << code;
	endfunction

	function automatic logic pllmc_loop_ok(input logic [6:0] code);
		pllmc_loop_ok = (code >= LOOP_DIVIDER_CODE_MIN) && (code <= LOOP_DIVIDER_CODE_MAX);
	endfunction
endpackage

// ===== pllmc_sync.sv
// Purpose: two-flop synchroniser for the lock level from the analogue loop
// Assumes: input may change at any time
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module pllmc_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// level in and out
	input wire logic async_in,
	output logic sync_out
);
	logic meta;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule // pllmc_sync
`default_nettype wire

// ===== pllmc_switch.sv
// Purpose: progressive clock switching sequencer for the system clock divider
// Assumes: loop_tick pulses once per loop output cycle, synchronous to clk_sys
// Notes: without the enable the loop clock is passed at divide by 1
`timescale 1ns/10ps
`default_nettype none
module pllmc_switch
	import pllmc_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// control
	input wire logic enable,
	input wire logic locked,
	input wire logic select,
	input wire logic loop_tick,
	// result
	output logic [1:0] div_code,
	output logic busy
);
	pllmc_sw_state_t state, next_state;
	logic [5:0] count;
	logic select_d;
	logic [5:0] dwell;
	logic dwell_end;
	logic start;

	assign start = select && !select_d && enable && locked;
	assign dwell = (state == PS_DIV8) ? DWELL_DIV8 : (state == PS_DIV4) ? DWELL_DIV4 : DWELL_DIV2;
	assign dwell_end = loop_tick && (count == dwell - 6'h01);
	assign busy = (state == PS_DIV8) || (state == PS_DIV4) || (state == PS_DIV2);

	// step from /8 down to /1
	always_comb begin
		next_state = state;
		case (state)
			PS_IDLE: if (start) next_state = PS_DIV8;
			PS_DIV8: if (dwell_end) next_state = PS_DIV4;
			PS_DIV4: if (dwell_end) next_state = PS_DIV2;
			PS_DIV2: if (dwell_end) next_state = PS_DONE;
			PS_DONE: if (!select) next_state = PS_IDLE;
			default: next_state = PS_IDLE;
		endcase
		if (!locked) begin
			next_state = PS_IDLE;
		end
	end

	// state, dwell counter and divider code
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= PS_IDLE;
			count <= 6'h00;
			select_d <= 1'b0;
			div_code <= 2'h0;
		end else begin
			state <= next_state;
			select_d <= select;
			count <= (next_state != state) ? 6'h00 : (loop_tick ? count + 6'h01 : count);
			case (next_state)
				PS_DIV8: div_code <= 2'h3;
				PS_DIV4: div_code <= 2'h2;
				PS_DIV2: div_code <= 2'h1;
				default: div_code <= 2'h0;
			endcase
		end
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	// first step after a start is divide by 8
	chk_switch_starts_div8: assert property (start && locked |=> div_code == 2'h3)
		else $error("progressive switching did not start at divide by 8");
endmodule // pllmc_switch
`default_nettype wire

// ===== pllmc_loop_model.sv
// Purpose: behavioural model of the analogue loop beside the control block
// Assumes: ticks are one-cycle pulses synchronous to clk_sys
// Notes: slow mode stretches the reference and loop periods
`timescale 1ns/10ps
`default_nettype none
module pllmc_loop_model #(
	parameter int LOCK_DELAY = 12
) (
	// clock
	input wire logic clk_sys,
	// bench control
	input wire logic lock_req,
	input wire logic slow,
	// loop outputs
	output logic ref_tick,
	output logic loop_tick,
	output logic pll_lock_async
);
	int ref_cnt = 0;
	int loop_cnt = 0;
	int lock_cnt = 0;
	initial begin
		ref_tick = 1'b0;
		loop_tick = 1'b0;
		pll_lock_async = 1'b0;
	end
	// tick pulses; slow mode gives the strobe counter a longer wait
	always @(posedge clk_sys) begin
		ref_cnt <= (ref_cnt >= (slow ? 7 : 3)) ? 0 : ref_cnt + 1;
		ref_tick <= (ref_cnt == 0);
		loop_cnt <= loop_cnt + 1;
		loop_tick <= (loop_cnt % (slow ? 5 : 2)) == 0;
	end
	// lock settles after a delay and drops at once; moved off the edge as it is asynchronous
	always @(posedge clk_sys) begin
		lock_cnt <= lock_req ? lock_cnt + 1 : 0;
		pll_lock_async <= #1 lock_req && (lock_cnt >= LOCK_DELAY);
	end
endmodule // pllmc_loop_model
`default_nettype wire

// ===== pll_divider_modulation_ctrl_tb.sv
// Purpose: self-checking bench of the divider and modulation control block
// Assumes: register reads are checked one cycle after the read strobe
// Notes: settle count shortened to 20 cycles for simulation
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module pll_divider_modulation_ctrl_tb;
	import pllmc_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic reg_supervisor = 1'b1;
	logic [31:0] reg_rdata;
	logic ref_tick, loop_tick, pll_lock_async;
	logic pll_powered = 1'b1;
	logic pll_select = 1'b0;
	logic lock_req = 1'b0;
	logic slow = 1'b0;
	logic [3:0] in_div_code;
	logic [4:0] in_div_ratio, out_div_ratio;
	logic ref_inhibit, loop_div_valid, switch_busy, mod_strobe, mod_active;
	logic [6:0] loop_div_code;
	logic [1:0] sys_div_code;
	logic mod_spread_type, pll_fail, clock_ready;
	logic [12:0] mod_period;
	logic [14:0] mod_inc_step;
	int miscompares = 0;
	int compares = 0;
	int sticks = 0;
	logic rd_pend = 1'b0;
	logic [31:0] exp_r;
	logic [31:0] expq[$];
	always #2 clk_sys = ~clk_sys;
	pllmc_ctrl #(.LOCK_SETTLE_CYCLES(20)) u_pllmc_ctrl (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_supervisor(reg_supervisor), .reg_rdata(reg_rdata), .ref_tick(ref_tick),
		.loop_tick(loop_tick), .pll_lock_async(pll_lock_async), .pll_powered(pll_powered),
		.pll_select(pll_select), .in_div_code(in_div_code), .in_div_ratio(in_div_ratio),
		.ref_inhibit(ref_inhibit), .out_div_ratio(out_div_ratio), .loop_div_code(loop_div_code),
		.loop_div_valid(loop_div_valid), .sys_div_code(sys_div_code), .switch_busy(switch_busy),
		.mod_strobe(mod_strobe), .mod_active(mod_active), .mod_spread_type(mod_spread_type),
		.mod_period(mod_period), .mod_inc_step(mod_inc_step), .pll_fail(pll_fail),
		.clock_ready(clock_ready));
	pllmc_loop_model u_pllmc_loop_model (.clk_sys(clk_sys), .lock_req(lock_req), .slow(slow),
		.ref_tick(ref_tick), .loop_tick(loop_tick), .pll_lock_async(pll_lock_async));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic sup);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_supervisor <= sup;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		expq.push_back(e);
		@(posedge clk_sys);
		reg_read <= 1'b0;
	endtask
	// waits for one strobe to rise and fall, returns the reference ticks it spanned
	task automatic wait_strobe(output int seen);
		int s0;
		s0 = sticks;
		for (int k = 0; k < 60 && mod_strobe !== 1'b1; k++) @(posedge clk_sys);
		for (int k = 0; k < 40 && mod_strobe === 1'b1; k++) @(posedge clk_sys);
		@(posedge clk_sys);
		seen = sticks - s0;
	endtask
	task final_report;
		if (miscompares == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// read data stands only in the cycle after the strobe, so compare it there
	always @(posedge clk_sys) begin
		if (rd_pend) begin
			exp_r = expq.pop_front();
			`CHK(reg_rdata, exp_r)
		end
		rd_pend <= reg_read;
	end
	// reference ticks seen while the strobe is high
	always @(posedge clk_sys) begin
		if (mod_strobe === 1'b1 && ref_tick === 1'b1) begin
			sticks <= sticks + 1;
		end
	end
	// watchdog: far beyond the expected run of under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		miscompares++;
		final_report;
	end
	initial begin
		logic [31:0] rnd;
		logic [6:0] nd;
		logic [1:0] od, prev;
		logic [1:0] seq[$];
		logic [6:0] bnd[4];
		int n;
		int seen;
		rnd = 32'hCE85;
		bnd = '{7'h1F, 7'h20, 7'h60, 7'h61};
		repeat (8) @(posedge clk_sys);
		reset <= 1'b0;
		rd(OFS_CONTROL, 32'h00002000);
		rd(OFS_MODULATION, 32'h0);
		`CHK(out_div_ratio, 5'h02)
		// every input code, range edges of the loop code first, then random
		for (int i = 0; i < 16; i++) begin
			rnd = nx(rnd);
			nd = (i < 4) ? bnd[i] : rnd[6:0];
			od = i[1:0];
			wr(OFS_CONTROL, {17'h0, nd, 2'h0, od, i[3:0]}, 1'b1);
			repeat (3) @(posedge clk_sys);
			`CHK(in_div_code, i[3:0])
			`CHK(in_div_ratio, {1'b0, i[3:0]} + 5'h01)
			`CHK(ref_inhibit, i == 15)
			`CHK(out_div_ratio, 5'h02 << od)
			`CHK(loop_div_code, nd)
			`CHK(loop_div_valid, nd >= 7'h20 && nd <= 7'h60)
			rd(OFS_CONTROL, {17'h0, nd, 2'h0, od, i[3:0]});
		end
		wr(OFS_CONTROL, 32'h00014001, 1'b1);
		wr(OFS_CONTROL, 32'h0, 1'b0);
		wr(8'h0C, 32'hFFFFFFFF, 1'b1);
		rd(OFS_CONTROL, 32'h00014001);
		rd(8'h08, 32'h0);
		// step 105: down depth 1, divider 64, period 40
		wr(OFS_MODULATION, 32'h006900A2, 1'b1);
		lock_req <= 1'b1;
		slow <= 1'b1;
		repeat (30) @(posedge clk_sys);
		`CHK(mod_period, 13'h0)
		rd(OFS_CONTROL, 32'h00074001);
		wr(OFS_CONTROL, 32'h00034001, 1'b1);
		rd(OFS_CONTROL, 32'h00054001);
		wr(OFS_MODULATION, 32'h006980A2, 1'b1);
		wait_strobe(seen);
		`CHK(seen, 2)
		`CHK(mod_period, 13'h0028)
		`CHK(mod_inc_step, 15'h0069)
		`CHK(mod_spread_type, 1'b1)
		`CHK(mod_active, 1'b1)
		// hold off selecting the loop clock until the settle time has run
		for (n = 0; n < 200 && clock_ready !== 1'b1; n++) @(posedge clk_sys);
		`CHK(clock_ready, 1'b1)
		// nothing here needs a constant clock while the steps run
		slow <= 1'b0;
		pll_select <= 1'b1;
		prev = 2'h0;
		repeat (300) begin
			@(posedge clk_sys);
			`CHK(switch_busy, sys_div_code != 2'h0)
			if (sys_div_code !== prev) begin
				seq.push_back(sys_div_code);
				prev = sys_div_code;
			end
		end
		`CHK({seq[0], seq[1], seq[2], seq[3]}, 8'hE4)
		`CHK(seq.size(), 4)
		lock_req <= 1'b0;
		repeat (12) @(posedge clk_sys);
		`CHK(pll_fail, 1'b1)
		`CHK(sys_div_code, 2'h0)
		`CHK(clock_ready, 1'b0)
		rd(OFS_CONTROL, 32'h00134001);
		wr(OFS_CONTROL, 32'h00094001, 1'b1);
		repeat (3) @(posedge clk_sys);
		`CHK(pll_fail, 1'b0)
		wr(OFS_CONTROL, 32'h001B4001, 1'b1);
		rd(OFS_CONTROL, 32'h00094001);
		// bypassed settings apply at once, here with the loop powered down
		pll_powered <= 1'b0;
		pll_select <= 1'b0;
		wr(OFS_MODULATION, 32'h006900C9, 1'b1);
		repeat (3) @(posedge clk_sys);
		`CHK(mod_period, 13'h0032)
		`CHK(mod_spread_type, 1'b0)
		`CHK(mod_active, 1'b0)
		// strobe from lock arriving while modulation is already enabled
		wr(OFS_MODULATION, 32'h006980A6, 1'b1);
		pll_powered <= 1'b1;
		lock_req <= 1'b1;
		repeat (3) @(posedge clk_sys);
		`CHK(mod_period, 13'h0032)
		wait_strobe(seen);
		`CHK(seen, 2)
		`CHK(mod_period, 13'h0029)
		`CHK(mod_spread_type, 1'b1)
		// loss of lock while powered down leaves the fail flag clear
		pll_powered <= 1'b0;
		lock_req <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rd(OFS_CONTROL, 32'h000B4001);
		repeat (3) @(posedge clk_sys);
		final_report;
	end
endmodule // pll_divider_modulation_ctrl_tb
`default_nettype wire
